/* File: design/scc_config_top.sv */
// Chosen here: the Wishbone register port.
module scc_config_top
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Shift engine bit strobes
  input wire logic RX_BIT_VALID,
  input wire logic RX_BIT,
  input wire logic TX_BIT_VALID,
  input wire logic TX_BIT,
  input wire logic PORT_BUSY,
  // Audio serial pins, sampled synchronously
  input wire logic AUDIO_CLK_IN,
  input wire logic WORD_SELECT_IN,
  // Configuration outputs
  output logic FRAME_16BIT,
  output logic AUDIO_ENABLED,
  output logic AUDIO_MASTER,
  output logic AUDIO_TRANSMIT,
  output logic [1:0] AUDIO_STANDARD,
  output logic FRAME_SYNC_LONG,
  output logic CLOCK_IDLE_HIGH,
  output logic [1:0] SAMPLE_LENGTH,
  output logic CHANNEL_32BIT,
  output logic MCLK_OUT_EN,
  output logic [8:0] CLOCK_DIVIDER,
  output logic TRANSFER_STARTED
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic checksum_enable;
    logic frame_format_select;
    logic [15:0] generator_polynomial;
    logic [15:0] acfg;
    logic [15:0] apre;
    logic ws_prev;
    logic clk_prev;
    logic armed;
    logic started;
    logic audio_on;
    logic master;
    logic transmit;
    logic [1:0] standard;
    logic sync_long;
    logic idle_high;
    logic [1:0] slen;
    logic ch32;
    logic mclk_oe;
    logic [8:0] divider;
  } scc_state_t;

  scc_state_t s_reg;
  scc_state_t s_next;

  scc_crc_if rx_if ();
  scc_crc_if tx_if ();

  logic req;
  logic do_wr;
  logic ck_clear;
  logic [15:0] wdat;

  // ==========================================================
  // Bus request decode
  assign req = WB_CYC_I && WB_STB_I;
  // Write lands on the same edge the master sees ack
  assign do_wr = req && WB_WE_I && s_reg.ack;
  assign wdat = WB_DAT_I[15:0];
  assign ck_clear = do_wr && (WB_ADR_I == SCC_CTRL_OFS) && WB_SEL_I[1]
                    && wdat[SCC_CTRL_CKEN_BIT];

  // ==========================================================
  // Checksum engines; idle in audio mode
  assign rx_if.clear = ck_clear;
  assign rx_if.enable = s_reg.checksum_enable && !s_reg.acfg[SCC_ACFG_MODE_BIT];
  assign rx_if.wide = s_reg.frame_format_select;
  assign rx_if.bit_valid = RX_BIT_VALID;
  assign rx_if.bit_val = RX_BIT;
  assign rx_if.poly = s_reg.generator_polynomial;

  assign tx_if.clear = ck_clear;
  assign tx_if.enable = s_reg.checksum_enable && !s_reg.acfg[SCC_ACFG_MODE_BIT];
  assign tx_if.wide = s_reg.frame_format_select;
  assign tx_if.bit_valid = TX_BIT_VALID;
  assign tx_if.bit_val = TX_BIT;
  assign tx_if.poly = s_reg.generator_polynomial;

  scc_crc_engine u_rx_crc (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .crc(rx_if.engine)
  );

  scc_crc_engine u_tx_crc (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .crc(tx_if.engine)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    logic audio_on;
    logic slave;
    logic ws_edge_ok;
    logic clk_edge;
    scc_role_t role;
    audio_on = 1'b0;
    slave = 1'b0;
    ws_edge_ok = 1'b0;
    clk_edge = 1'b0;
    role = scc_role_t'(s_reg.acfg[SCC_ACFG_ROLE_LSB +: 2]);
    s_next = s_reg;

    // Single-wait classic cycle: ack one cycle after request, then dropped
    s_next.ack = req && !s_reg.ack;
    s_next.rdata = 32'h0000_0000;
    if (req && !s_reg.ack && !WB_WE_I)
    begin
      // Unmapped addresses read zero and still ack
      if (WB_ADR_I == SCC_CTRL_OFS)
      begin
        s_next.rdata[SCC_CTRL_CKEN_BIT] = s_reg.checksum_enable;
        s_next.rdata[SCC_CTRL_FFS_BIT] = s_reg.frame_format_select;
      end
      else if (WB_ADR_I == SCC_STAT_OFS)
        s_next.rdata[SCC_STAT_BUSY_BIT] = PORT_BUSY;
      else if (WB_ADR_I == SCC_POLY_OFS)
        s_next.rdata[15:0] = s_reg.generator_polynomial;
      else if (WB_ADR_I == SCC_RXCK_OFS)
        s_next.rdata[15:0] = rx_if.value;
      else if (WB_ADR_I == SCC_TXCK_OFS)
        s_next.rdata[15:0] = tx_if.value;
      else if (WB_ADR_I == SCC_ACFG_OFS)
        s_next.rdata[15:0] = s_reg.acfg & SCC_ACFG_MASK;
      else if (WB_ADR_I == SCC_APRE_OFS)
        s_next.rdata[15:0] = s_reg.apre & SCC_APRE_MASK;
    end

    if (do_wr)
    begin
      if (WB_ADR_I == SCC_CTRL_OFS)
      begin
        if (WB_SEL_I[1])
        begin
          s_next.checksum_enable = wdat[SCC_CTRL_CKEN_BIT];
          s_next.frame_format_select = wdat[SCC_CTRL_FFS_BIT];
        end
      end
      else if (WB_ADR_I == SCC_POLY_OFS)
        s_next.generator_polynomial = scc_merge(s_reg.generator_polynomial, wdat,
                                                WB_SEL_I[1:0], 16'hffff);
      else if (WB_ADR_I == SCC_ACFG_OFS)
        s_next.acfg = scc_merge(s_reg.acfg, wdat, WB_SEL_I[1:0], SCC_ACFG_MASK);
      else if (WB_ADR_I == SCC_APRE_OFS)
        // Prescaler 0/1 is stored as written; software keeps clear of it
        s_next.apre = scc_merge(s_reg.apre, wdat, WB_SEL_I[1:0], SCC_APRE_MASK);
    end

    // Registered configuration outputs
    audio_on = s_reg.acfg[SCC_ACFG_MODE_BIT] && s_reg.acfg[SCC_ACFG_EN_BIT];
    slave = (role == SCC_SLAVE_TX) || (role == SCC_SLAVE_RX);
    s_next.audio_on = audio_on;
    s_next.master = !slave;
    s_next.transmit = (role == SCC_SLAVE_TX) || (role == SCC_MASTER_TX);
    s_next.standard = s_reg.acfg[SCC_ACFG_STD_LSB +: 2];
    s_next.sync_long = s_reg.acfg[SCC_ACFG_SYNC_BIT]
                       && (s_reg.acfg[SCC_ACFG_STD_LSB +: 2] == SCC_STD_PCM);
    s_next.idle_high = s_reg.acfg[SCC_ACFG_CPOL_BIT];
    // Code 11 is passed through untouched; software never writes it
    s_next.slen = s_reg.acfg[SCC_ACFG_SLEN_LSB +: 2];
    s_next.ch32 = (s_reg.acfg[SCC_ACFG_SLEN_LSB +: 2] != SCC_SLEN_16)
                  || s_reg.acfg[SCC_ACFG_CHANNEL_LENGTH_BIT];
    s_next.mclk_oe = audio_on && !slave && s_reg.apre[SCC_APRE_MASTER_CLOCK_OUTPUT_ENABLE_BIT];
    s_next.divider = {s_reg.apre[7:0], s_reg.apre[SCC_APRE_ODD_BIT]};

    // Slave start detection
    s_next.ws_prev = WORD_SELECT_IN;
    s_next.clk_prev = AUDIO_CLK_IN;
    clk_edge = AUDIO_CLK_IN != s_reg.clk_prev;
    if (s_reg.acfg[SCC_ACFG_STD_LSB +: 2] == SCC_STD_PHILIPS)
      ws_edge_ok = s_reg.ws_prev && !WORD_SELECT_IN;
    else
      ws_edge_ok = !s_reg.ws_prev && WORD_SELECT_IN;

    if (!audio_on)
    begin
      s_next.armed = 1'b0;
      s_next.started = 1'b0;
    end
    else if (!slave)
      s_next.started = 1'b1;
    else if (!s_reg.started)
    begin
      if (s_reg.acfg[SCC_ACFG_ASYNC_BIT])
        s_next.started = clk_edge;
      else
      begin
        // Armed by the word-select edge, launched by the next clock edge
        if (ws_edge_ok)
          s_next.armed = 1'b1;
        s_next.started = s_reg.armed && clk_edge;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_reg <= '0;
      s_reg.generator_polynomial <= SCC_POLY_RESET;
      s_reg.acfg <= SCC_ACFG_RESET;
      s_reg.apre <= SCC_APRE_RESET;
      s_reg.divider <= {SCC_APRE_RESET[7:0], 1'b0};
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================
  // Outputs
  assign WB_ACK_O = s_reg.ack;
  assign WB_DAT_O = s_reg.rdata;
  assign FRAME_16BIT = s_reg.frame_format_select;
  assign AUDIO_ENABLED = s_reg.audio_on;
  assign AUDIO_MASTER = s_reg.master;
  assign AUDIO_TRANSMIT = s_reg.transmit;
  assign AUDIO_STANDARD = s_reg.standard;
  assign FRAME_SYNC_LONG = s_reg.sync_long;
  assign CLOCK_IDLE_HIGH = s_reg.idle_high;
  assign SAMPLE_LENGTH = s_reg.slen;
  assign CHANNEL_32BIT = s_reg.ch32;
  assign MCLK_OUT_EN = s_reg.mclk_oe;
  assign CLOCK_DIVIDER = s_reg.divider;
  assign TRANSFER_STARTED = s_reg.started;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_wr(logic [7:0] ofs);
    req && WB_WE_I && WB_ACK_O && (WB_ADR_I == ofs) && (WB_SEL_I[1:0] == 2'h3);
  endsequence

  property p_poly_write;
    logic [15:0] d;
    (s_wr(SCC_POLY_OFS), d = WB_DAT_I[15:0]) |=> (s_reg.generator_polynomial == d);
  endproperty
  a_poly_write: assert property (p_poly_write) else $error("polynomial not stored");

  property p_clear;
    s_wr(SCC_CTRL_OFS) ##0 WB_DAT_I[SCC_CTRL_CKEN_BIT] |=>
      (rx_if.value == SCC_CKSUM_RESET) && (tx_if.value == SCC_CKSUM_RESET);
  endproperty
  a_clear: assert property (p_clear) else $error("checksums not cleared");

  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_sync_start;
    (AUDIO_ENABLED && !AUDIO_MASTER && !s_reg.acfg[SCC_ACFG_ASYNC_BIT]
     && $rose(TRANSFER_STARTED)) |-> $past(s_reg.armed);
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("start without ws edge");

  property p_async_start;
    (s_reg.audio_on && !s_reg.master && s_reg.acfg[SCC_ACFG_ASYNC_BIT] && !s_reg.started
     && s_next.audio_on && (AUDIO_CLK_IN != s_reg.clk_prev)) |=> TRANSFER_STARTED;
  endproperty
  a_async_start: assert property (p_async_start) else $error("async start missed");

  property p_no_spi_audio;
    !s_reg.acfg[SCC_ACFG_MODE_BIT] |=> !AUDIO_ENABLED && !MCLK_OUT_EN && !TRANSFER_STARTED;
  endproperty
  a_no_spi_audio: assert property (p_no_spi_audio) else $error("audio active in SPI mode");

  property p_ch32;
    (s_reg.acfg[SCC_ACFG_SLEN_LSB +: 2] != SCC_SLEN_16) |=> CHANNEL_32BIT;
  endproperty
  a_ch32: assert property (p_ch32) else $error("channel not forced wide");

  property p_divider;
    ##1 (CLOCK_DIVIDER == 9'(2 * $past(s_reg.apre[7:0]) + $past(s_reg.apre[SCC_APRE_ODD_BIT])));
  endproperty
  a_divider: assert property (p_divider) else $error("divider mismatch");

  property p_rsvd;
    (req && !WB_WE_I && !WB_ACK_O && (WB_ADR_I == SCC_ACFG_OFS)) |=>
      (WB_DAT_O[15:13] == 3'h0) && (WB_DAT_O[6] == 1'b0) && (WB_DAT_O[31:16] == 16'h0000);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule

/* File: design/scc_crc_engine.sv */
module scc_crc_engine
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Checksum channel
  scc_crc_if.engine crc
);

  typedef struct packed {
    logic [15:0] value_reg;
  } scc_crc_state_t;

  scc_crc_state_t s_reg;
  scc_crc_state_t s_next;

  // ==========================================================
  // Accumulator
  always_comb
  begin
    s_next = s_reg;
    if (crc.clear)
    begin
      s_next.value_reg = SCC_CKSUM_RESET;
    end
    else if (crc.enable && crc.bit_valid)
    begin
      s_next.value_reg = scc_crc_step(s_reg.value_reg, crc.poly, crc.bit_val, crc.wide);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '{value_reg: SCC_CKSUM_RESET};
    else
      s_reg <= s_next;
  end

  assign crc.value = s_reg.value_reg;

  // ==========================================================
  // Checks
  property p_crc_shift;
    @(posedge clk) disable iff (!rst_n)
    (crc.enable && crc.bit_valid && !crc.clear) |=>
      (crc.value == scc_crc_step($past(crc.value), $past(crc.poly), $past(crc.bit_val),
                                 $past(crc.wide)));
  endproperty
  a_crc_shift: assert property (p_crc_shift) else $error("checksum shift wrong");

  property p_crc_narrow;
    @(posedge clk) disable iff (!rst_n)
    (!crc.wide && crc.bit_valid && crc.enable) |=> (crc.value[15:8] == 8'h00);
  endproperty
  a_crc_narrow: assert property (p_crc_narrow) else $error("narrow checksum high byte");

endmodule

/* File: design/scc_crc_if.sv */
interface scc_crc_if;
  import scc_pkg::*;
  logic clear;
  logic enable;
  logic wide;
  logic bit_valid;
  logic bit_val;
  logic [15:0] poly;
  logic [15:0] value;

  modport ctrl (output clear, output enable, output wide, output bit_valid,
                output bit_val, output poly, input value);
  modport engine (input clear, input enable, input wide, input bit_valid,
                  input bit_val, input poly, output value);
endinterface

/* File: design/scc_pkg.sv */
package scc_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] SCC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SCC_STAT_OFS = 8'h08;
  localparam logic [7:0] SCC_POLY_OFS = 8'h10;
  localparam logic [7:0] SCC_RXCK_OFS = 8'h14;
  localparam logic [7:0] SCC_TXCK_OFS = 8'h18;
  localparam logic [7:0] SCC_ACFG_OFS = 8'h1c;
  localparam logic [7:0] SCC_APRE_OFS = 8'h20;

  // ==========================================================
  // Field positions
  localparam int SCC_CTRL_CKEN_BIT = 13;
  localparam int SCC_CTRL_FFS_BIT = 11;
  localparam int SCC_STAT_BUSY_BIT = 7;
  localparam int SCC_ACFG_ASYNC_BIT = 12;
  localparam int SCC_ACFG_MODE_BIT = 11;
  localparam int SCC_ACFG_EN_BIT = 10;
  localparam int SCC_ACFG_ROLE_LSB = 8;
  localparam int SCC_ACFG_SYNC_BIT = 7;
  localparam int SCC_ACFG_STD_LSB = 4;
  localparam int SCC_ACFG_CPOL_BIT = 3;
  localparam int SCC_ACFG_SLEN_LSB = 1;
  localparam int SCC_ACFG_CHANNEL_LENGTH_BIT = 0;
  localparam int SCC_APRE_MASTER_CLOCK_OUTPUT_ENABLE_BIT = 9;
  localparam int SCC_APRE_ODD_BIT = 8;

  // ==========================================================
  // Writable bit masks and reset values
  localparam logic [15:0] SCC_CTRL_MASK = 16'h2800;
  localparam logic [15:0] SCC_ACFG_MASK = 16'h1fbf;
  localparam logic [15:0] SCC_APRE_MASK = 16'h03ff;
  localparam logic [15:0] SCC_POLY_RESET = 16'h0007;
  localparam logic [15:0] SCC_ACFG_RESET = 16'h0000;
  localparam logic [15:0] SCC_APRE_RESET = 16'h0002;
  localparam logic [15:0] SCC_CKSUM_RESET = 16'h0000;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    SCC_SLAVE_TX,
    SCC_SLAVE_RX,
    SCC_MASTER_TX,
    SCC_MASTER_RX
  } scc_role_t;

  typedef enum logic [1:0] {
    SCC_STD_PHILIPS,
    SCC_STD_MSB_JUST,
    SCC_STD_LSB_JUST,
    SCC_STD_PCM
  } scc_std_t;

  localparam logic [1:0] SCC_SLEN_16 = 2'h0;

  // One shift of the checksum; narrow mode keeps the high byte at zero
  function automatic logic [15:0] scc_crc_step(input logic [15:0] crc,
                                               input logic [15:0] poly,
                                               input logic din,
                                               input logic wide);
    logic fb;
    logic [15:0] nxt;
    fb = din ^ (wide ? crc[15] : crc[7]);
    nxt = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    return wide ? nxt : {8'h00, nxt[7:0]};
  endfunction

  // Byte-lane merge of a 16-bit register, reserved bits held at zero
  function automatic logic [15:0] scc_merge(input logic [15:0] old,
                                            input logic [15:0] wdat,
                                            input logic [1:0] sel,
                                            input logic [15:0] mask);
    logic [15:0] m;
    m = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
    return m & mask;
  endfunction

endpackage

/* File: sim/scc_peer_model.sv */
module scc_peer_model
(
  // Clock
  input wire logic clk,
  // Shift engine strobes
  output logic rx_vld,
  output logic rx_b,
  output logic tx_vld,
  output logic tx_b,
  output logic busy,
  // Audio pins
  output logic aclk,
  output logic ws
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    rx_vld = 1'b0;
    rx_b = 1'b0;
    tx_vld = 1'b0;
    tx_b = 1'b0;
    busy = 1'b0;
    aclk = 1'b0;
    ws = 1'b0;
  end

  // ==========================================================
  // Frame shifting, MSB first, one bit a cycle
  task automatic shift(input logic tx, input logic [15:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk);
      busy <= 1'b1;
      if (tx)
      begin
        tx_vld <= 1'b1;
        tx_b <= d[i];
      end
      else
      begin
        rx_vld <= 1'b1;
        rx_b <= d[i];
      end
    end
    @(posedge clk);
    rx_vld <= 1'b0;
    tx_vld <= 1'b0;
    // Released lines flip so a stale bit is never mistaken for data
    rx_b <= ~rx_b;
    tx_b <= ~tx_b;
    busy <= 1'b0;
  endtask

  // ==========================================================
  // Audio clock stands still except on request
  task automatic clk_edge();
    @(posedge clk);
    aclk <= ~aclk;
  endtask

  task automatic ws_drive(input logic v);
    @(posedge clk);
    ws <= v;
  endtask

  // Busy level on its own, for status reads mid-transfer
  task automatic hold_busy(input logic v);
    @(posedge clk);
    busy <= v;
  endtask
endmodule

/* File: sim/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scc_pkg::*;

  logic clk, rst_n, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, q, rdat;
  logic ack, rxv, rxb, txv, txb, busy, aclk, ws;
  logic f16, aen, ams, atx, fsl, cih, ch32, mck, tst;
  logic [1:0] astd, slen;
  logic [8:0] cdiv;
  int failures, cmp_count, cycles;

  scc_config_top uut (.CLOCK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .RX_BIT_VALID(rxv), .RX_BIT(rxb), .TX_BIT_VALID(txv), .TX_BIT(txb),
    .PORT_BUSY(busy), .AUDIO_CLK_IN(aclk), .WORD_SELECT_IN(ws), .FRAME_16BIT(f16),
    .AUDIO_ENABLED(aen), .AUDIO_MASTER(ams), .AUDIO_TRANSMIT(atx), .AUDIO_STANDARD(astd),
    .FRAME_SYNC_LONG(fsl), .CLOCK_IDLE_HIGH(cih), .SAMPLE_LENGTH(slen),
    .CHANNEL_32BIT(ch32), .MCLK_OUT_EN(mck), .CLOCK_DIVIDER(cdiv), .TRANSFER_STARTED(tst));

  scc_peer_model peer (.clk(clk), .rx_vld(rxv), .rx_b(rxb), .tx_vld(txv), .tx_b(txb),
    .busy(busy), .aclk(aclk), .ws(ws));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("Mismatches %0d of %0d comparisons", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // ==========================================================
  // Classic Wishbone single cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {2'h0, s};
    dat <= {16'h0000, d};
    // No timeout here; ack ends this wait, or else the hang guard
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wb(1'b1, a, d, 2'h3);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000, 2'h3);
    chk(q, {16'h0000, e});
  endtask

  // Checksum reference, MSB first
  function automatic logic [15:0] crc_m(input logic [15:0] c, input logic [15:0] p,
                                        input logic [15:0] d, input int n, input logic w);
    logic fb;
    for (int i = n - 1; i >= 0; i--)
    begin
      fb = d[i] ^ (w ? c[15] : c[7]);
      c = {c[14:0], 1'b0} ^ (fb ? p : 16'h0000);
      if (!w)
        c[15:8] = 8'h00;
    end
    return c;
  endfunction

  initial
  begin
    {rst_n, cyc, stb, we, adr, sel, dat} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and access kinds
    rdchk(SCC_POLY_OFS, 16'h0007);
    rdchk(SCC_RXCK_OFS, 16'h0000);
    rdchk(SCC_TXCK_OFS, 16'h0000);
    rdchk(SCC_ACFG_OFS, 16'h0000);
    rdchk(SCC_APRE_OFS, 16'h0002);
    chk(32'(cdiv), 32'h4);
    wr(SCC_RXCK_OFS, 16'hffff);
    rdchk(SCC_RXCK_OFS, 16'h0000);
    rdchk(8'h3c, 16'h0000);
    wb(1'b1, SCC_POLY_OFS, 16'habcd, 2'h1);
    rdchk(SCC_POLY_OFS, 16'h00cd);
    wr(SCC_POLY_OFS, 16'h8005);
    rdchk(SCC_POLY_OFS, 16'h8005);
    // Prescaler never 0 or 1, written while audio off
    wr(SCC_APRE_OFS, 16'hffff);
    rdchk(SCC_APRE_OFS, 16'h03ff);
    chk(32'(cdiv), 32'h1ff);
    wr(SCC_APRE_OFS, 16'h0205);
    chk(32'(cdiv), 32'h00a);
    wr(SCC_ACFG_OFS, 16'hfffb);
    rdchk(SCC_ACFG_OFS, 16'h1fbb);
    wr(SCC_ACFG_OFS, 16'h0000);
    // Checksums in both frame widths
    wr(SCC_CTRL_OFS, 16'h2800);
    peer.shift(1'b0, 16'h1234, 16);
    repeat (2) @(posedge clk);
    rdchk(SCC_RXCK_OFS, crc_m(16'h0, 16'h8005, 16'h1234, 16, 1'b1));
    chk(32'(f16), 32'h1);
    rdchk(SCC_STAT_OFS, 16'h0000);
    peer.hold_busy(1'b1);
    rdchk(SCC_STAT_OFS, 16'h0080);
    peer.hold_busy(1'b0);
    wr(SCC_CTRL_OFS, 16'h2000);
    rdchk(SCC_RXCK_OFS, 16'h0000);
    chk(32'(f16), 32'h0);
    peer.shift(1'b1, 16'h00a5, 8);
    repeat (2) @(posedge clk);
    rdchk(SCC_TXCK_OFS, crc_m(16'h0, 16'h8005, 16'h00a5, 8, 1'b0));
    wr(SCC_ACFG_OFS, 16'h0800);
    peer.shift(1'b0, 16'h00ff, 8);
    repeat (2) @(posedge clk);
    rdchk(SCC_RXCK_OFS, 16'h0000);
    // Enable has no effect in SPI mode
    wr(SCC_ACFG_OFS, 16'h0400);
    chk(32'(aen), 32'h0);
    // Roles, standards, sync and polarity
    for (int i = 0; i < 4; i++)
    begin
      wr(SCC_ACFG_OFS, 16'h0000);
      wr(SCC_ACFG_OFS, 16'h0c88 | 16'(i << 8) | 16'(i << 4));
      chk(32'({aen, ams, atx, astd, fsl, cih}),
          32'({1'b1, i[1], ~i[0], i[1:0], i == 3, 1'b1}));
      chk(32'(mck), 32'(i[1]));
      chk(32'(tst), 32'(i[1]));
    end
    wr(SCC_ACFG_OFS, 16'h0000);
    chk(32'(mck), 32'h0);
    // Sample and channel length
    for (int i = 0; i < 6; i++)
    begin
      wr(SCC_ACFG_OFS, 16'(i));
      chk(32'({slen, ch32}), 32'({i[2:1], (i[2:1] != 2'h0) | i[0]}));
      chk(32'(cih), 32'h0);
    end
    // Synchronous slave start, Philips then justified
    wr(SCC_ACFG_OFS, 16'h0d00);
    peer.ws_drive(1'b1);
    peer.clk_edge();
    repeat (3) @(posedge clk);
    chk(32'(tst), 32'h0);
    peer.ws_drive(1'b0);
    peer.clk_edge();
    repeat (3) @(posedge clk);
    chk(32'(tst), 32'h1);
    wr(SCC_ACFG_OFS, 16'h0000);
    chk(32'(tst), 32'h0);
    // Word select parked high first, so the falling edge is seen before the rising one
    peer.ws_drive(1'b1);
    wr(SCC_ACFG_OFS, 16'h0d10);
    peer.ws_drive(1'b0);
    peer.clk_edge();
    repeat (3) @(posedge clk);
    chk(32'(tst), 32'h0);
    peer.ws_drive(1'b1);
    peer.clk_edge();
    repeat (3) @(posedge clk);
    chk(32'(tst), 32'h1);
    // Asynchronous slave start on first clock
    wr(SCC_ACFG_OFS, 16'h0000);
    wr(SCC_ACFG_OFS, 16'h1d00);
    chk(32'(tst), 32'h0);
    peer.clk_edge();
    repeat (3) @(posedge clk);
    chk(32'(tst), 32'h1);
    end_sim();
  end
endmodule
